/* slm_pkg.sv */
// constants and types shared by the link error monitor
package slm_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 50;          // 20 MHz system clock
   localparam int RX_TIMEOUT_US     = 1000;        // no-frame period before timeout alarm
   localparam int RX_TIMEOUT_CYC    = (RX_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   localparam int BLINK_HALF_MS     = 250;         // indicator on and off time
   localparam int BLINK_HALF_CYC    = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
   localparam int TMO_W             = 24;          // width of the timeout and blink counters

   // ----------------------------------------------------------------
   // persistence of reception errors, in communication cycles
   // ----------------------------------------------------------------
   localparam int             PERSIST_W     = 8;
   localparam logic [7:0]     PERSIST_READS = 8'h08;

   // ----------------------------------------------------------------
   // alarm codes, written in decimal as main.sub
   // ----------------------------------------------------------------
   localparam logic [7:0] ALM_MAIN_CONT   = 8'h53;  // 83
   localparam logic [7:0] ALM_SUB_CONT1   = 8'h00;  // 83.0
   localparam logic [7:0] ALM_SUB_CONT2   = 8'h01;  // 83.1
   localparam logic [7:0] ALM_MAIN_TMO    = 8'h54;  // 84
   localparam logic [7:0] ALM_SUB_TMO     = 8'h00;  // 84.0
   localparam logic [7:0] RESP_BYTE1_ALM  = 8'hff;  // response byte 1 during alarm 83.0 or 83.1

   // ----------------------------------------------------------------
   // reset values and widths
   // ----------------------------------------------------------------
   localparam int         DATA_W          = 32;
   localparam logic [31:0] RX_DATA_RST    = 32'h0000_0000;
   localparam logic [7:0]  CODE_RST       = 8'h00;

   typedef enum logic {LINK_INITIAL, LINK_RUNNING} slm_link_t;
   typedef enum logic [1:0] {ALM_NONE, ALM_CONT1, ALM_CONT2, ALM_TIMEOUT} slm_alarm_t;

endpackage

/* slm_cnt_if.sv */
// carrier between the monitor and one persistence counter
`timescale 1ns/1ns
interface slm_cnt_if #(parameter int W = 8);
   logic         step;     // advance by one
   logic         clear;    // back to zero, wins over step
   logic [W-1:0] limit;    // count at which expired rises
   logic         expired;  // count has reached limit

   modport owner   (output step, output clear, output limit, input expired);
   modport counter (input step, input clear, input limit, output expired);
endinterface

/* slm_persist_cnt.sv */
// saturating persistence counter
`timescale 1ns/1ns
module slm_persist_cnt #(
   parameter int W = 8
) (
   input wire logic   clk,   // system clock
   input wire logic   rst,   // async reset, active high
   slm_cnt_if.counter cif    // step, clear, limit, expired
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // ----------------------------------------------------------------
   // next count: clear first, then step until the limit
   // ----------------------------------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      if (cif.clear) begin
         cnt_next = '0;
      end else if (cif.step && (cnt_reg < cif.limit)) begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   // register the count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign cif.expired = (cnt_reg >= cif.limit);
endmodule

/* slm_monitor.sv */
// reception error supervision of a servo network node
`timescale 1ns/1ns
module slm_monitor
   import slm_pkg::*;
#(
   parameter int TIMEOUT_CYC = RX_TIMEOUT_CYC,   // no-frame timeout in clocks
   parameter int BLINK_CYC   = BLINK_HALF_CYC    // indicator half period in clocks
) (
   input  wire logic              clk,                    // system clock
   input  wire logic              rst,                    // async reset, active high
   input  wire logic              link_start,             // init done, enter RUNNING
   input  wire logic              sync_lock,              // cycle-to-servo sync reached
   input  wire logic              frame_arrive,           // a frame reached the node
   input  wire logic              miss_start,             // missing-reception start signal
   input  wire logic              cycle_read,             // received data read this cycle
   input  wire logic              crc_err,                // crc failure, with cycle_read
   input  wire logic              rx_missing,             // nothing received, with cycle_read
   input  wire logic              cyclic_err,             // cyclic error, with cycle_read
   input  wire logic              cmd_alarm_clear,        // alarm clear command, with cycle_read
   input  wire logic [DATA_W-1:0] rx_data,                // received command data
   input  wire logic [7:0]        resp_byte1_in,          // normal response byte 1
   output logic                   link_running,           // link state is RUNNING
   output logic                   sync_ok,                // cycle-to-servo sync held
   output logic [DATA_W-1:0]      cmd_data,               // last good command data
   output logic [7:0]             resp_byte1,             // response byte 1 to send
   output logic                   servo_alarm,            // servo in alarm status
   output logic [7:0]             alarm_main,             // current alarm main code
   output logic [7:0]             alarm_sub,              // current alarm sub code
   output logic                   alarm_log,              // one-cycle history write
   output logic                   link_status_indicator   // red indicator, flashing
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   slm_link_t         link_reg,  link_next;
   logic              sync_reg,  sync_next;
   slm_alarm_t        alm_reg,   alm_next;
   logic [DATA_W-1:0] data_reg,  data_next;
   logic [7:0]        main_reg,  main_next;
   logic [7:0]        sub_reg,   sub_next;
   logic              log_reg,   log_next;
   logic [7:0]        byte1_reg, byte1_next;
   logic [TMO_W-1:0]  blink_cnt_reg, blink_cnt_next;
   logic              blink_reg, blink_next;

   slm_cnt_if #(.W(PERSIST_W)) crc_if  ();
   slm_cnt_if #(.W(PERSIST_W)) any_if  ();
   slm_cnt_if #(.W(TMO_W))     tmo_if  ();

   // ----------------------------------------------------------------
   // qualified events of one read
   // ----------------------------------------------------------------
   logic judge;
   logic miss_q;
   logic read_err;
   logic read_good;
   logic clear_ok;
   logic tmo_hit;
   logic cont1_hit;
   logic cont2_hit;

   assign judge     = cycle_read && (link_reg == LINK_RUNNING);
   assign miss_q    = rx_missing && sync_reg;
   assign read_err  = judge && (crc_err || miss_q || cyclic_err);
   assign read_good = judge && !crc_err && !rx_missing && !cyclic_err;
   assign clear_ok  = read_good && cmd_alarm_clear;
   assign tmo_hit   = (link_reg == LINK_RUNNING) && tmo_if.expired;
   assign cont1_hit = crc_if.expired;
   assign cont2_hit = any_if.expired && !crc_if.expired;

   // ----------------------------------------------------------------
   // persistence counters
   // ----------------------------------------------------------------
   // run of crc failures; any other read breaks it, except a missing read without sync
   assign crc_if.step  = judge && crc_err;
   assign crc_if.clear = (judge && !crc_err && (rx_missing ? sync_reg : 1'b1)) || clear_ok
                         || (link_reg != LINK_RUNNING);
   assign crc_if.limit = PERSIST_READS;

   // run of any qualifying error; a good read breaks it
   assign any_if.step  = read_err;
   assign any_if.clear = read_good || (link_reg != LINK_RUNNING);
   assign any_if.limit = PERSIST_READS;

   // clocks with neither a frame nor a missing-reception start
   assign tmo_if.step  = (link_reg == LINK_RUNNING);
   assign tmo_if.clear = frame_arrive || miss_start || (link_reg != LINK_RUNNING);
   assign tmo_if.limit = TMO_W'(TIMEOUT_CYC);

   slm_persist_cnt #(.W(PERSIST_W)) u_crc_cnt (
      .clk (clk),
      .rst (rst),
      .cif (crc_if.counter)
   );

   slm_persist_cnt #(.W(PERSIST_W)) u_any_cnt (
      .clk (clk),
      .rst (rst),
      .cif (any_if.counter)
   );

   slm_persist_cnt #(.W(TMO_W)) u_tmo_cnt (
      .clk (clk),
      .rst (rst),
      .cif (tmo_if.counter)
   );

   // ----------------------------------------------------------------
   // link state, sync and alarm
   // ----------------------------------------------------------------
   always_comb begin
      link_next = link_reg;
      sync_next = sync_reg;
      alm_next  = alm_reg;
      main_next = main_reg;
      sub_next  = sub_reg;
      log_next  = 1'b0;
      if (clear_ok && (alm_reg != ALM_NONE)) begin
         alm_next  = ALM_NONE;
         main_next = CODE_RST;
         sub_next  = CODE_RST;
      end
      unique case (link_reg)
         LINK_INITIAL: begin
            if (link_start) begin
               link_next = LINK_RUNNING;
            end
         end
         LINK_RUNNING: begin
            if (tmo_hit) begin
               link_next = LINK_INITIAL;
               sync_next = 1'b0;
               alm_next  = ALM_TIMEOUT;
               main_next = ALM_MAIN_TMO;
               sub_next  = ALM_SUB_TMO;
               log_next  = 1'b1;
            end else if (alm_reg == ALM_NONE) begin
               // raise only when none stands; a clearing read breaks both runs, so an
               // expiry still held in the saturated counters must not raise it again
               if (cont1_hit) begin
                  alm_next  = ALM_CONT1;
                  main_next = ALM_MAIN_CONT;
                  sub_next  = ALM_SUB_CONT1;
                  log_next  = 1'b1;
               end else if (cont2_hit) begin
                  alm_next  = ALM_CONT2;
                  main_next = ALM_MAIN_CONT;
                  sub_next  = ALM_SUB_CONT2;
                  log_next  = 1'b1;
               end
            end
         end
      endcase
      if (sync_lock && link_reg == LINK_RUNNING && !tmo_hit) begin
         sync_next = 1'b1;
      end
   end

   // register link and alarm state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_reg <= LINK_INITIAL;
         sync_reg <= 1'b0;
         alm_reg  <= ALM_NONE;
         main_reg <= CODE_RST;
         sub_reg  <= CODE_RST;
         log_reg  <= 1'b0;
      end else begin
         link_reg <= link_next;
         sync_reg <= sync_next;
         alm_reg  <= alm_next;
         main_reg <= main_next;
         sub_reg  <= sub_next;
         log_reg  <= log_next;
      end
   end

   // ----------------------------------------------------------------
   // data path: hold last good data, mark response byte 1
   // ----------------------------------------------------------------
   always_comb begin
      data_next = data_reg;
      if (read_good) begin
         data_next = rx_data;
      end
      if (alm_next == ALM_CONT1 || alm_next == ALM_CONT2) begin
         byte1_next = RESP_BYTE1_ALM;
      end else begin
         byte1_next = resp_byte1_in;
      end
   end

   // register data outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_reg  <= RX_DATA_RST;
         byte1_reg <= CODE_RST;
      end else begin
         data_reg  <= data_next;
         byte1_reg <= byte1_next;
      end
   end

   // ----------------------------------------------------------------
   // indicator flash
   // ----------------------------------------------------------------
   always_comb begin
      blink_cnt_next = blink_cnt_reg;
      blink_next     = blink_reg;
      if (alm_reg == ALM_NONE) begin
         blink_cnt_next = '0;
         blink_next     = 1'b0;
      end else if (blink_cnt_reg >= TMO_W'(BLINK_CYC - 1)) begin
         blink_cnt_next = '0;
         blink_next     = !blink_reg;
      end else begin
         blink_cnt_next = blink_cnt_reg + TMO_W'(1);
      end
   end

   // register the flash timer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
         blink_reg     <= blink_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link_running          = (link_reg == LINK_RUNNING);
   assign sync_ok               = sync_reg;
   assign cmd_data              = data_reg;
   assign resp_byte1            = byte1_reg;
   assign servo_alarm           = (alm_reg != ALM_NONE);
   assign alarm_main            = main_reg;
   assign alarm_sub             = sub_reg;
   assign alarm_log             = log_reg;
   assign link_status_indicator = !blink_reg && (alm_reg != ALM_NONE);
endmodule

/* slm_monitor_asserts.sv */
// concurrent checks on the link error monitor ports
`timescale 1ns/1ns
module slm_monitor_asserts
   import slm_pkg::*;
#(
   parameter int TIMEOUT_CYC = 50,   // no-frame timeout in clocks
   parameter int BLINK_CYC   = 4     // indicator half period
) (
   input wire logic              clk,                    // system clock
   input wire logic              rst,                    // async reset
   input wire logic              frame_arrive,           // frame seen
   input wire logic              miss_start,             // missing start
   input wire logic              cycle_read,             // read strobe
   input wire logic              crc_err,                // crc failure
   input wire logic              rx_missing,             // nothing received
   input wire logic              cyclic_err,             // cyclic error
   input wire logic              cmd_alarm_clear,        // clear command
   input wire logic [DATA_W-1:0] rx_data,                // received data
   input wire logic [7:0]        resp_byte1_in,          // normal byte 1
   input wire logic              link_running,           // link state
   input wire logic              sync_ok,                // sync held
   input wire logic [DATA_W-1:0] cmd_data,               // good data
   input wire logic [7:0]        resp_byte1,             // byte 1 sent
   input wire logic              servo_alarm,            // alarm status
   input wire logic [7:0]        alarm_main,             // main code
   input wire logic [7:0]        alarm_sub,              // sub code
   input wire logic              alarm_log,              // history strobe
   input wire logic              link_status_indicator   // red indicator
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [15:0] idle_reg;    // clocks running with no frame
   logic [15:0] idle_next;
   logic        good_rd;     // error-free read this cycle

   // count silent clocks while running
   always_comb begin
      idle_next = idle_reg + 16'h0001;
      if (!link_running || frame_arrive || miss_start) begin
         idle_next = 16'h0000;
      end
   end

   // register the silent-clock count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle_reg <= 16'h0000;
      end else begin
         idle_reg <= idle_next;
      end
   end
   assign good_rd = link_running && cycle_read && !crc_err && !rx_missing && !cyclic_err;

   log_pulse_a: assert property (alarm_log |=> !alarm_log) else $error("history strobe longer than one clock");
   // the alarm registers one clock after the counter reaches its limit
   crc_run_a: assert property ((link_running && cycle_read && crc_err && !rx_missing
      && !cyclic_err && !servo_alarm)[*8]
      |=> ##1 (servo_alarm && alarm_main == ALM_MAIN_CONT && alarm_sub == ALM_SUB_CONT1))
      else $error("crc run gave no alarm");
   resp_alarm_a: assert property (alarm_main == ALM_MAIN_CONT |-> resp_byte1 == RESP_BYTE1_ALM)
      else $error("byte 1 not ff during alarm");
   resp_pass_a: assert property (!$past(rst) && alarm_main != ALM_MAIN_CONT
      |-> resp_byte1 == $past(resp_byte1_in))
      else $error("byte 1 not passed through");
   link_fall_a: assert property ($fell(link_running) |-> alarm_main == ALM_MAIN_TMO
      && alarm_sub == ALM_SUB_TMO && int'($past(idle_reg)) >= TIMEOUT_CYC - 3)
      else $error("link left running without timeout");
   idle_bound_a: assert property (link_running |-> int'(idle_reg) <= TIMEOUT_CYC + 2)
      else $error("timeout alarm late");
   sync_gate_a: assert property (!link_running |-> !sync_ok) else $error("sync held outside running");
   cmd_hold_a: assert property ((link_running && cycle_read && (crc_err || cyclic_err))[*2]
      |=> $stable(cmd_data))
      else $error("bad frame loaded");
   clear_ok_a: assert property (good_rd && cmd_alarm_clear |=> !servo_alarm && alarm_main == CODE_RST)
      else $error("clear not accepted");
   led_blink_a: assert property (not ((servo_alarm && link_status_indicator)[*6]))
      else $error("indicator not flashing");
   led_dark_a: assert property (!servo_alarm [*2] |-> !link_status_indicator) else $error("indicator lit");
   led_first_a: assert property ($rose(servo_alarm) |-> link_status_indicator)
      else $error("indicator not lit when alarm raised");
endmodule

bind slm_monitor slm_monitor_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .BLINK_CYC(BLINK_CYC)) slm_monitor_asserts_inst (
   .clk(clk), .rst(rst), .frame_arrive(frame_arrive), .miss_start(miss_start), .cycle_read(cycle_read),
   .crc_err(crc_err), .rx_missing(rx_missing), .cyclic_err(cyclic_err), .cmd_alarm_clear(cmd_alarm_clear),
   .rx_data(rx_data), .resp_byte1_in(resp_byte1_in), .link_running(link_running), .sync_ok(sync_ok),
   .cmd_data(cmd_data), .resp_byte1(resp_byte1), .servo_alarm(servo_alarm), .alarm_main(alarm_main),
   .alarm_sub(alarm_sub), .alarm_log(alarm_log), .link_status_indicator(link_status_indicator));

/* slm_host_model.sv */
// host controller model feeding the node's reception side
`timescale 1ns/1ns
module slm_host_model
   import slm_pkg::*;
(
   input wire logic          clk,              // system clock
   output logic              link_start,       // link start pulse
   output logic              sync_lock,        // sync reached pulse
   output logic              frame_arrive,     // frame pulse
   output logic              miss_start,       // missing start pulse
   output logic              cycle_read,       // read strobe
   output logic              crc_err,          // crc failure
   output logic              rx_missing,       // missing reception
   output logic              cyclic_err,       // cyclic error
   output logic              cmd_alarm_clear,  // clear command
   output logic [DATA_W-1:0] rx_data,          // command data
   output logic [7:0]        resp_byte1_in     // normal byte 1
);
   // quiet lines at time zero
   initial begin
      {link_start, sync_lock, frame_arrive, miss_start, cycle_read} = 5'h00;
      {crc_err, rx_missing, cyclic_err, cmd_alarm_clear} = 4'h0;
      rx_data = 32'h0000_0000;
      resp_byte1_in = 8'h5a;
   end

   // one-clock start or sync pulse; restarting after a timeout is the host's job
   task automatic pulse(input logic lk, input logic sy);
      link_start = lk;
      sync_lock = sy;
      @(negedge clk);
      link_start = 1'b0;
      sync_lock = 1'b0;
   endtask

   // n back-to-back reads, kinds alternate k0/k1: 0 good, 1 crc, 2 missing, 3 cyclic
   task automatic reads(input int n, input logic [1:0] k0, input logic [1:0] k1, input logic clr,
                        input logic [DATA_W-1:0] d);
      logic [1:0] k;
      for (int i = 0; i < n; i++) begin
         k = i[0] ? k1 : k0;
         cycle_read = 1'b1;
         crc_err = (k == 2'h1);
         rx_missing = (k == 2'h2);
         cyclic_err = (k == 2'h3);
         frame_arrive = (k != 2'h2);
         miss_start = (k == 2'h2);
         cmd_alarm_clear = clr;
         rx_data = d + DATA_W'(i);
         @(negedge clk);
      end
      {cycle_read, crc_err, rx_missing, cyclic_err, cmd_alarm_clear, frame_arrive, miss_start} = 7'h00;
      rx_data = ~rx_data;  // data no longer qualified, so show no stale copy
   endtask
endmodule

/* tb_servo_link_error_monitor.sv */
// self-checking bench for the link error monitor
`timescale 1ns/1ns
module tb_servo_link_error_monitor;
   import slm_pkg::*;
   logic clk, rst, ls, sl, fa, ms, cr, ce, rm, ye, cc, run, syn, alm, lg, led;
   logic [DATA_W-1:0] rxd, cmd;
   logic [7:0] rbi, rb, amain, asub;
   int error_cnt, n_tests;

   slm_host_model slm_host_model_inst (.clk(clk), .link_start(ls), .sync_lock(sl), .frame_arrive(fa),
      .miss_start(ms), .cycle_read(cr), .crc_err(ce), .rx_missing(rm), .cyclic_err(ye), .cmd_alarm_clear(cc),
      .rx_data(rxd), .resp_byte1_in(rbi));
   slm_monitor #(.TIMEOUT_CYC(50), .BLINK_CYC(4)) slm_monitor_inst (.clk(clk), .rst(rst), .link_start(ls),
      .sync_lock(sl), .frame_arrive(fa), .miss_start(ms), .cycle_read(cr), .crc_err(ce), .rx_missing(rm),
      .cyclic_err(ye), .cmd_alarm_clear(cc), .rx_data(rxd), .resp_byte1_in(rbi), .link_running(run),
      .sync_ok(syn), .cmd_data(cmd), .resp_byte1(rb), .servo_alarm(alm), .alarm_main(amain), .alarm_sub(asub),
      .alarm_log(lg), .link_status_indicator(led));

   // compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // reads while the link is still initial are ignored
   task automatic t_initial();
      slm_host_model_inst.reads(8, 2'h1, 2'h1, 1'b0, 32'h0000_0011);
      @(negedge clk);
      chk("alarm initial", 32'h0, alm);
      chk("cmd initial", 32'h0, cmd);
      $display("test initial done");
   endtask

   // seven crc reads stay quiet, eight raise 83.0, then clear
   task automatic t_alarm1();
      slm_host_model_inst.pulse(1'b1, 1'b0);
      @(negedge clk);
      slm_host_model_inst.pulse(1'b0, 1'b1);
      chk("running", 32'h1, run);
      slm_host_model_inst.reads(1, 2'h0, 2'h0, 1'b0, 32'h1234_5678);
      @(negedge clk);
      slm_host_model_inst.reads(7, 2'h1, 2'h1, 1'b0, 32'hdead_0000);
      @(negedge clk);
      chk("alarm after 7", 32'h0, alm);
      slm_host_model_inst.reads(1, 2'h0, 2'h0, 1'b0, 32'h1234_5678);
      @(negedge clk);
      slm_host_model_inst.reads(8, 2'h1, 2'h1, 1'b0, 32'hdead_0000);
      @(negedge clk);
      chk("log", 32'h1, lg);
      chk("main", 32'(ALM_MAIN_CONT), amain);
      chk("sub", 32'(ALM_SUB_CONT1), asub);
      chk("byte1", 32'hff, rb);
      chk("servo alarm", 32'h1, alm);
      chk("kept data", 32'h1234_5678, cmd);
      chk("still running", 32'h1, run);
      chk("led lit", 32'h1, led);
      slm_host_model_inst.reads(1, 2'h0, 2'h0, 1'b1, 32'h0bad_cafe);
      @(negedge clk);
      chk("cleared", 32'h0, alm);
      chk("byte1 back", 32'(rbi), rb);
      $display("test alarm1 done");
   endtask

   // alternating crc and cyclic errors give 83.1
   task automatic t_alarm2();
      slm_host_model_inst.reads(8, 2'h1, 2'h3, 1'b0, 32'h0000_0022);
      @(negedge clk);
      chk("mixed main", 32'(ALM_MAIN_CONT), amain);
      chk("mixed sub", 32'(ALM_SUB_CONT2), asub);
      chk("mixed led lit", 32'h1, led);
      repeat (4) @(negedge clk);
      chk("mixed led dark", 32'h0, led);
      slm_host_model_inst.reads(1, 2'h0, 2'h0, 1'b1, 32'h0000_0033);
      @(negedge clk);
      chk("cleared 2", 32'h0, alm);
      $display("test alarm2 done");
   endtask

   // silence gives 84.0, then missing reads count only with sync
   task automatic t_timeout();
      repeat (60) @(negedge clk);
      chk("link dropped", 32'h0, run);
      chk("sync dropped", 32'h0, syn);
      chk("tmo main", 32'(ALM_MAIN_TMO), amain);
      chk("tmo sub", 32'(ALM_SUB_TMO), asub);
      slm_host_model_inst.pulse(1'b1, 1'b0);
      slm_host_model_inst.reads(1, 2'h0, 2'h0, 1'b1, 32'h0000_0044);
      @(negedge clk);
      chk("tmo cleared", 32'h0, alm);
      slm_host_model_inst.reads(8, 2'h2, 2'h2, 1'b0, 32'h0000_0055);
      @(negedge clk);
      chk("missing no sync", 32'h0, alm);
      slm_host_model_inst.pulse(1'b0, 1'b1);
      slm_host_model_inst.reads(8, 2'h2, 2'h2, 1'b0, 32'h0000_0066);
      @(negedge clk);
      chk("missing sub", 32'(ALM_SUB_CONT2), asub);
      $display("test timeout done");
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_initial();
      t_alarm1();
      t_alarm2();
      t_timeout();
      tally_and_finish();
   end
endmodule
